/* fcpc_ctrl.sv */
/*
  Flash command sequencer with range protection for a 64 KB flash window.
  Two-stage command queue, protection decode and upgrade-only checks,
  divided timebase, status flags with interrupt enables.
  Assumes inputs synchronous to clock and a single array behind flash_* pins.
*/
//
// Contract
// - Open polarity plus disable bits decide protected or unprotected ranges.
// - High size selects F800, F000, E000 or C000 up to FFFF.
// - Low size selects 4000 up to 43FF, 47FF, 4FFF or 5FFF.
// - Protection loads from array after reset; software may still change it.
// - Only scenario transitions that add protection are accepted; range sizes are not checked.
// - Invalid protection writes are dropped; register unchanged.
// - Protection reads return the scenario currently in force.
// - Program and erase run on ticks from a programmable oscillator divider.
// - Command, address and data form a two-deep queue.
// - Back-to-back programs on same row keep high voltage on.
// - Buffer-empty and complete flags each raise interrupt when enabled.
// - Mass erase steps flash_addr from 0000 through 0400 only.
// - Writing one to buffer-empty flag clears it and launches command.
// - Mass erase over any protected part sets violation, no launch.
// - Complete flag sets after a program or erase unless another command is queued.
// - Reserved slot reads zero and ignores writes.
`timescale 1ns/10ps
`include "fcpc_defines.svh"
module fcpc_ctrl import fcpc_pkg::*; #(
  parameter int DIV_W = 8,
  parameter int ROW_BITS = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Protection setting from array after reset
  input wire logic [7:0] prot_load_value,
  input wire logic prot_load_valid,
  // Software protection write
  input wire logic [7:0] prot_write_value,
  input wire logic prot_write,
  // Divider
  input wire logic [DIV_W-1:0] div_write_value,
  input wire logic div_write,
  // Command write sequence
  input wire logic array_write,
  input wire logic [15:0] array_write_addr,
  input wire logic [15:0] array_write_data,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_write_value,
  input wire logic launch_write,
  input wire logic violation_clear,
  // Interrupt enables
  input wire logic buffer_empty_ie,
  input wire logic command_complete_ie,
  // Reserved slot
  input wire logic reserved_write,
  input wire logic [7:0] reserved_write_value,
  // Status
  output logic [7:0] protection_register,
  output logic [DIV_W-1:0] clock_divider,
  output logic div_loaded,
  output logic buffer_empty_flag,
  output logic command_complete_flag,
  output logic protection_violation_flag,
  output logic buffer_empty_irq,
  output logic command_complete_irq,
  output logic [7:0] reserved_slot,
  // Flash array operations
  output logic flash_hv_on,
  output logic flash_program,
  output logic flash_mass_erase,
  output logic [15:0] flash_addr,
  output logic [15:0] flash_data
);

  // ----------------------------------------
  // Protection decode
  // ----------------------------------------
  fcpc_cmd_t buf_stage;
  function automatic logic [2:0] scenario_of(input logic [7:0] p);
    logic o;
    logic hd;
    logic ld;
    o = p[`FCPC_PROT_OPEN_BIT];
    hd = p[`FCPC_PROT_HDIS_BIT];
    ld = p[`FCPC_PROT_LDIS_BIT];
    if (o && hd && ld)
      scenario_of = 3'd7;
    else if (o && hd)
      scenario_of = 3'd5;
    else if (o && ld)
      scenario_of = 3'd6;
    else if (o)
      scenario_of = 3'd4;
    else if (hd && ld)
      scenario_of = 3'd3;
    else if (hd)
      scenario_of = 3'd1;
    else if (ld)
      scenario_of = 3'd2;
    else
      scenario_of = 3'd0;
  endfunction

  // Upgrade-only table; 7 is the open array, 3 the fully protected one
  function automatic logic transition_ok(input logic [2:0] f, input logic [2:0] t);
    case (f)
      3'd7: transition_ok = 1'b1;
      3'd0: transition_ok = (t == 3'd0) || (t == 3'd1) || (t == 3'd2) || (t == 3'd3);
      3'd1: transition_ok = (t == 3'd1) || (t == 3'd3);
      3'd2: transition_ok = (t == 3'd2) || (t == 3'd3);
      3'd3: transition_ok = (t == 3'd3);
      3'd4: transition_ok = (t == 3'd3) || (t == 3'd4);
      3'd5: transition_ok = (t >= 3'd2) && (t <= 3'd5);
      3'd6: transition_ok = (t == 3'd1) || (t == 3'd3) || (t == 3'd4) || (t == 3'd6);
      default: transition_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] high_base(input logic [1:0] s);
    case (s)
      2'b00: high_base = `FCPC_HIGH_BASE_0;
      2'b01: high_base = `FCPC_HIGH_BASE_1;
      2'b10: high_base = `FCPC_HIGH_BASE_2;
      default: high_base = `FCPC_HIGH_BASE_3;
    endcase
  endfunction

  function automatic logic [15:0] low_end(input logic [1:0] s);
    case (s)
      2'b00: low_end = `FCPC_LOW_END_0;
      2'b01: low_end = `FCPC_LOW_END_1;
      2'b10: low_end = `FCPC_LOW_END_2;
      default: low_end = `FCPC_LOW_END_3;
    endcase
  endfunction

  wire logic prot_open = protection_register[`FCPC_PROT_OPEN_BIT];
  wire logic high_dis = protection_register[`FCPC_PROT_HDIS_BIT];
  wire logic low_dis = protection_register[`FCPC_PROT_LDIS_BIT];
  wire logic [1:0] high_size =
    protection_register[`FCPC_PROT_HS_HI:`FCPC_PROT_HS_LO];
  wire logic [1:0] low_size =
    protection_register[`FCPC_PROT_LS_HI:`FCPC_PROT_LS_LO];
  wire logic [15:0] high_start = high_base(high_size);
  wire logic [15:0] low_stop = low_end(low_size);
  // Any protected address anywhere: mass erase touches the whole array
  wire logic any_protected =
    prot_open ? (!high_dis || !low_dis)
              : 1'b1;
  // Single-address check; closed polarity turns the ranges into holes
  wire logic in_high = !high_dis && (buf_stage.addr >= high_start);
  wire logic in_low = !low_dis && (buf_stage.addr >= `FCPC_LOW_BASE) &&
    (buf_stage.addr <= low_stop);
  wire logic addr_protected = prot_open ? (in_high || in_low) : !(in_high || in_low);
  wire logic [2:0] cur_scn = scenario_of(protection_register);
  wire logic [2:0] new_scn = scenario_of(prot_write_value);
  wire logic prot_accept = transition_ok(cur_scn, new_scn);

  // ----------------------------------------
  // Protection register
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      protection_register <= `FCPC_PROT_RESET;
    end else if (prot_load_valid) begin
      protection_register <= prot_load_value;
    end else if (prot_write && prot_accept) begin
      protection_register <= prot_write_value;
    end
  end

  // ----------------------------------------
  // Divider and timebase
  // ----------------------------------------
  logic tick;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_divider <= '0;
      div_loaded <= 1'b0;
    end else if (div_write) begin
      clock_divider <= div_write_value;
      div_loaded <= 1'b1;
    end
  end

  fcpc_tick_div #(.DIV_W(DIV_W)) fcpc_tick_div_inst (
    .clock(clock),
    .rst(rst),
    .div_value(clock_divider),
    .div_valid(div_loaded),
    .tick(tick)
  );

  // ----------------------------------------
  // Two-stage command queue
  // ----------------------------------------
  fcpc_cmd_t run_stage;
  logic run_valid;
  logic pending_valid;
  logic seq_addr_seen;
  fcpc_state_t state;
  logic [15:0] tick_count;
  logic [15:0] erase_ptr;

  wire logic is_erase = (buf_stage.cmd == `FCPC_CMD_MASS_ERASE);
  wire logic launch_req = launch_write && seq_addr_seen && buffer_empty_flag;
  // Launch blocked when the queued command hits protection
  wire logic launch_block = launch_req && (is_erase ? any_protected : addr_protected);
  wire logic launch_go = launch_req && !launch_block;
  wire logic run_done;
  wire logic take_next = pending_valid && (!run_valid || run_done);
  wire logic same_row = pending_valid && run_valid &&
    buf_stage.cmd == `FCPC_CMD_PROGRAM && run_stage.cmd == `FCPC_CMD_PROGRAM &&
    buf_stage.addr[15:ROW_BITS] == run_stage.addr[15:ROW_BITS];
  wire logic [15:0] op_ticks =
    (run_stage.cmd == `FCPC_CMD_MASS_ERASE) ? `FCPC_ERASE_TICKS : `FCPC_PROG_TICKS;
  assign run_done = (state == FCPC_RUN) && tick && (tick_count == op_ticks);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_stage <= '0;
      seq_addr_seen <= 1'b0;
      pending_valid <= 1'b0;
      buffer_empty_flag <= 1'b1;
    end else begin
      if (array_write && buffer_empty_flag) begin
        buf_stage.addr <= array_write_addr;
        buf_stage.data <= array_write_data;
        seq_addr_seen <= 1'b1;
      end
      if (cmd_write && seq_addr_seen && buffer_empty_flag) begin
        buf_stage.cmd <= cmd_write_value;
      end
      if (launch_go) begin
        pending_valid <= 1'b1;
        seq_addr_seen <= 1'b0;
      end else if (take_next) begin
        pending_valid <= 1'b0;
      end
      if (launch_write && seq_addr_seen && buffer_empty_flag) begin
        buffer_empty_flag <= launch_block;
      end else if (take_next) begin
        buffer_empty_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Sequencer on flash ticks
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= FCPC_IDLE;
      run_stage <= '0;
      run_valid <= 1'b0;
      tick_count <= '0;
      erase_ptr <= '0;
      flash_hv_on <= 1'b0;
      flash_program <= 1'b0;
      flash_mass_erase <= 1'b0;
      flash_addr <= '0;
      flash_data <= '0;
    end else begin
      flash_program <= 1'b0;
      case (state)
        FCPC_IDLE: begin
          if (take_next) begin
            run_stage <= buf_stage;
            run_valid <= 1'b1;
            tick_count <= '0;
            state <= FCPC_RAMP;
          end
        end
        FCPC_RAMP: begin
          flash_hv_on <= 1'b1;
          if (tick) begin
            tick_count <= tick_count + 16'h0001;
            if (tick_count == `FCPC_HV_RAMP_TICKS) begin
              tick_count <= '0;
              erase_ptr <= '0;
              state <= FCPC_RUN;
            end
          end
        end
        default: begin
          flash_addr <= (run_stage.cmd == `FCPC_CMD_MASS_ERASE) ? erase_ptr : run_stage.addr;
          flash_data <= run_stage.data;
          flash_mass_erase <= (run_stage.cmd == `FCPC_CMD_MASS_ERASE);
          flash_program <= (run_stage.cmd == `FCPC_CMD_PROGRAM);
          if (tick) begin
            tick_count <= tick_count + 16'h0001;
            erase_ptr <= erase_ptr + 16'h0001;
          end
          if (run_done) begin
            flash_mass_erase <= 1'b0;
            tick_count <= '0;
            if (take_next) begin
              run_stage <= buf_stage;
              // Same row keeps the pump up and skips the ramp
              state <= same_row ? FCPC_RUN : FCPC_RAMP;
              flash_hv_on <= same_row;
            end else begin
              run_valid <= 1'b0;
              flash_hv_on <= 1'b0;
              state <= FCPC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      command_complete_flag <= 1'b1;
      protection_violation_flag <= 1'b0;
      buffer_empty_irq <= 1'b0;
      command_complete_irq <= 1'b0;
      reserved_slot <= 8'h00;
    end else begin
      if (run_done && !pending_valid) begin
        command_complete_flag <= 1'b1;
      end else if (take_next) begin
        command_complete_flag <= 1'b0;
      end
      if (launch_block) begin
        protection_violation_flag <= 1'b1;
      end else if (violation_clear) begin
        protection_violation_flag <= 1'b0;
      end
      buffer_empty_irq <= buffer_empty_flag && buffer_empty_ie;
      command_complete_irq <= command_complete_flag && command_complete_ie;
      // Writes go nowhere
      reserved_slot <= 8'h00;
    end
  end

  // Reserved slot writes are dropped on purpose
  wire logic unused_ok = ^{reserved_write, reserved_write_value};
endmodule

/* fcpc_defines.svh */
/*
  Offsets-free constant header for the flash command and protection controller:
  field positions, reset values, command codes and timing counts.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef FCPC_DEFINES_SVH
`define FCPC_DEFINES_SVH

// ----------------------------------------
// Protection register fields
// ----------------------------------------
`define FCPC_PROT_OPEN_BIT 7
`define FCPC_PROT_HDIS_BIT 5
`define FCPC_PROT_HS_HI 4
`define FCPC_PROT_HS_LO 3
`define FCPC_PROT_LDIS_BIT 2
`define FCPC_PROT_LS_HI 1
`define FCPC_PROT_LS_LO 0
`define FCPC_PROT_RESET 8'hff

// ----------------------------------------
// Array geometry and ranges
// ----------------------------------------
`define FCPC_ARRAY_TOP 16'hffff
`define FCPC_HIGH_BASE_0 16'hf800
`define FCPC_HIGH_BASE_1 16'hf000
`define FCPC_HIGH_BASE_2 16'he000
`define FCPC_HIGH_BASE_3 16'hc000
`define FCPC_LOW_BASE 16'h4000
`define FCPC_LOW_END_0 16'h43ff
`define FCPC_LOW_END_1 16'h47ff
`define FCPC_LOW_END_2 16'h4fff
`define FCPC_LOW_END_3 16'h5fff

// ----------------------------------------
// Commands and timing
// ----------------------------------------
`define FCPC_CMD_MASS_ERASE 8'h41
`define FCPC_CMD_PROGRAM 8'h20
`define FCPC_DIV_RESET 8'h00
`define FCPC_PROG_TICKS 16'h0008
`define FCPC_ERASE_TICKS 16'h0400
`define FCPC_HV_RAMP_TICKS 16'h0002

`endif

/* fcpc_pkg.sv */
/*
  Types shared by the flash command and protection controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcpc_pkg;
  typedef enum logic [1:0] {
    FCPC_IDLE,
    FCPC_RAMP,
    FCPC_RUN
  } fcpc_state_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } fcpc_cmd_t;
endpackage

/* fcpc_tick_div.sv */
/*
  Programmable divider: turns the oscillator-rate clock into one-cycle
  flash timing ticks. Assumes the divider value is written before use.
*/
`timescale 1ns/10ps
module fcpc_tick_div import fcpc_pkg::*; #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic [DIV_W-1:0] div_value,
  input wire logic div_valid,
  // Tick out
  output logic tick
);
  logic [DIV_W-1:0] count;
  wire logic at_end = (count >= div_value);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (!div_valid) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= at_end ? '0 : count + 1'b1;
      tick <= at_end;
    end
  end
endmodule

/* fcpc_ctrl_assertions.sv */
/*
  Checker for fcpc_ctrl: concurrent properties on its ports.
  Assumes it is bound to every fcpc_ctrl instance; one clock domain.
*/
`timescale 1ns/10ps
`include "fcpc_defines.svh"
module fcpc_ctrl_assertions import fcpc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests
  input wire logic prot_load_valid,
  input wire logic prot_write,
  input wire logic [7:0] prot_write_value,
  input wire logic array_write,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_write_value,
  input wire logic launch_write,
  input wire logic buffer_empty_ie,
  input wire logic command_complete_ie,
  // Status
  input wire logic [7:0] protection_register,
  input wire logic buffer_empty_flag,
  input wire logic command_complete_flag,
  input wire logic protection_violation_flag,
  input wire logic buffer_empty_irq,
  input wire logic command_complete_irq,
  input wire logic [7:0] reserved_slot,
  input wire logic flash_mass_erase
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic all_open;
  logic drops_prot;
  assign all_open = protection_register[7] & protection_register[5] & protection_register[2];
  // Only the open-polarity case is judged; closed-polarity moves are too loose
  assign drops_prot = protection_register[7] & prot_write_value[7] &
    ((prot_write_value[5] & ~protection_register[5]) |
    (prot_write_value[2] & ~protection_register[2]));

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_erase_cmd;
    array_write && buffer_empty_flag
    ##1 cmd_write && cmd_write_value == `FCPC_CMD_MASS_ERASE
    ##1 launch_write && buffer_empty_flag;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_RESERVED_ZERO: assert property (reserved_slot == 8'h00)
    else $error("reserved slot not zero");
  AST_EMPTY_IRQ: assert property (!$past(rst) |->
    buffer_empty_irq == $past(buffer_empty_flag && buffer_empty_ie))
    else $error("buffer empty irq wrong");
  AST_DONE_IRQ: assert property (!$past(rst) |->
    command_complete_irq == $past(command_complete_flag && command_complete_ie))
    else $error("command complete irq wrong");
  AST_LAUNCH_TAKES: assert property (seq_erase_cmd |=>
    !buffer_empty_flag || protection_violation_flag)
    else $error("launch did not take buffer");
  AST_ERASE_RUNS: assert property (seq_erase_cmd ##0 all_open |->
    ##[1:1000] flash_mass_erase)
    else $error("mass erase never started");
  AST_ERASE_REFUSED: assert property (seq_erase_cmd ##0 !all_open |=>
    protection_violation_flag && buffer_empty_flag)
    else $error("protected erase not refused");
  AST_NO_REMOVE: assert property (prot_write && !prot_load_valid && drops_prot |=>
    $stable(protection_register))
    else $error("protection removed by write");
  AST_PROT_STEADY: assert property (!$past(rst) && !$past(prot_write) &&
    !$past(prot_load_valid) |-> $stable(protection_register))
    else $error("protection changed without write");
endmodule

bind fcpc_ctrl fcpc_ctrl_assertions fcpc_ctrl_assertions_inst (
  .clock(clock), .rst(rst), .prot_load_valid(prot_load_valid), .prot_write(prot_write),
  .prot_write_value(prot_write_value), .array_write(array_write), .cmd_write(cmd_write),
  .cmd_write_value(cmd_write_value), .launch_write(launch_write),
  .buffer_empty_ie(buffer_empty_ie), .command_complete_ie(command_complete_ie),
  .protection_register(protection_register), .buffer_empty_flag(buffer_empty_flag),
  .command_complete_flag(command_complete_flag),
  .protection_violation_flag(protection_violation_flag),
  .buffer_empty_irq(buffer_empty_irq), .command_complete_irq(command_complete_irq),
  .reserved_slot(reserved_slot), .flash_mass_erase(flash_mass_erase));

/* fcpc_flash_model.sv */
/*
  Behavioural flash array beside fcpc_ctrl: hands over the stored
  protection byte after reset and counts mass erase starts.
  Assumes the bench sets image before it releases reset.
*/
`timescale 1ns/10ps
module fcpc_flash_model import fcpc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Stored protection byte
  input wire logic [7:0] image,
  // To controller
  output logic [7:0] prot_load_value,
  output logic prot_load_valid,
  // From controller
  input wire logic flash_mass_erase,
  // Observation
  output logic [7:0] erase_count
);
  logic [1:0] wait_cnt;
  logic erase_q;
  // Outside the load pulse the bus shows the inverse, never a stale byte
  assign prot_load_value = prot_load_valid ? image : ~image;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_cnt <= 2'h0;
      prot_load_valid <= 1'b0;
      erase_q <= 1'b0;
      erase_count <= 8'h00;
    end else begin
      // Read-out takes a few cycles after reset
      if (wait_cnt != 2'h3) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
      prot_load_valid <= (wait_cnt == 2'h2);
      erase_q <= flash_mass_erase;
      if (flash_mass_erase && !erase_q) begin
        erase_count <= erase_count + 8'h01;
      end
    end
  end
endmodule

/* flash_cmd_protect_ctrl_test.sv */
/*
  Self-checking bench for fcpc_ctrl with the flash array model.
  Assumes a 100 MHz clock; inputs change 1 ns after each rising edge.
*/
`timescale 1ns/10ps
`include "fcpc_defines.svh"
module flash_cmd_protect_ctrl_test import fcpc_pkg::*;;
  logic clock, rst, prot_load_valid, prot_write, div_write, array_write, cmd_write;
  logic launch_write, violation_clear, buffer_empty_ie, command_complete_ie, reserved_write;
  logic div_loaded, buffer_empty_flag, command_complete_flag, protection_violation_flag;
  logic buffer_empty_irq, command_complete_irq, flash_hv_on, flash_program, flash_mass_erase;
  logic [7:0] image, prot_load_value, prot_write_value, cmd_write_value, reserved_write_value;
  logic [7:0] protection_register, reserved_slot, erase_count, div_write_value, clock_divider;
  logic [15:0] array_write_addr, array_write_data, flash_addr, flash_data;
  int n_errors, n_checks;

  fcpc_ctrl fcpc_ctrl_inst (.clock(clock), .rst(rst), .prot_load_value(prot_load_value),
    .prot_load_valid(prot_load_valid), .prot_write_value(prot_write_value),
    .prot_write(prot_write), .div_write_value(div_write_value), .div_write(div_write),
    .array_write(array_write), .array_write_addr(array_write_addr),
    .array_write_data(array_write_data), .cmd_write(cmd_write),
    .cmd_write_value(cmd_write_value), .launch_write(launch_write),
    .violation_clear(violation_clear), .buffer_empty_ie(buffer_empty_ie),
    .command_complete_ie(command_complete_ie), .reserved_write(reserved_write),
    .reserved_write_value(reserved_write_value), .protection_register(protection_register),
    .clock_divider(clock_divider), .div_loaded(div_loaded),
    .buffer_empty_flag(buffer_empty_flag), .command_complete_flag(command_complete_flag),
    .protection_violation_flag(protection_violation_flag),
    .buffer_empty_irq(buffer_empty_irq), .command_complete_irq(command_complete_irq),
    .reserved_slot(reserved_slot), .flash_hv_on(flash_hv_on), .flash_program(flash_program),
    .flash_mass_erase(flash_mass_erase), .flash_addr(flash_addr), .flash_data(flash_data));
  fcpc_flash_model fcpc_flash_model_inst (.clock(clock), .rst(rst), .image(image),
    .prot_load_value(prot_load_value), .prot_load_valid(prot_load_valid),
    .flash_mass_erase(flash_mass_erase), .erase_count(erase_count));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return command_complete_flag;
      1: return prot_load_valid;
      2: return buffer_empty_flag;
      3: return flash_mass_erase;
      default: return flash_program;
    endcase
  endfunction
  // Erase length depends on the divider, so the bound is generous
  task automatic wait_is(input int k, input logic v);
    int i;
    for (i = 0; i < 30000 && sel(k) !== v; i++) begin
      step();
    end
    if (i == 30000) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic do_reset(input logic [7:0] stored);
    image = stored;
    rst = 1'b1;
    repeat (4) step();
    rst = 1'b0;
    wait_is(1, 1'b1);
    step();
    div_write_value = 8'h01;
    div_write = 1'b1;
    step();
    div_write = 1'b0;
  endtask
  task automatic pulse_prot(input logic [7:0] v);
    prot_write_value = v;
    prot_write = 1'b1;
    step();
    prot_write = 1'b0;
    step();
  endtask
  task automatic do_cmd(input logic [7:0] c);
    array_write = 1'b1;
    step();
    array_write = 1'b0;
    cmd_write_value = c;
    cmd_write = 1'b1;
    step();
    cmd_write = 1'b0;
    launch_write = 1'b1;
    step();
    launch_write = 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {rst, prot_write, div_write, array_write, cmd_write, launch_write} = 6'h20;
    {violation_clear, reserved_write, buffer_empty_ie, command_complete_ie} = 4'h3;
    {image, prot_write_value, cmd_write_value, reserved_write_value} = 32'hff00_0000;
    {div_write_value, array_write_addr, array_write_data} = {8'h00, 16'h8000, 16'h1234};
    n_errors = 0;
    n_checks = 0;
    do_reset(8'hff);
    chk("prot_load", protection_register, 8'hff);
    chk("divider", clock_divider, 8'h01);
    chk("div_loaded", div_loaded, 1'b1);
    chk("empty_irq", buffer_empty_irq, 1'b1);
    do_cmd(`FCPC_CMD_MASS_ERASE);
    chk("empty_launch", buffer_empty_flag, 1'b0);
    wait_is(3, 1'b1);
    chk("done_running", command_complete_flag, 1'b0);
    do_cmd(`FCPC_CMD_MASS_ERASE);
    chk("queue_full", buffer_empty_flag, 1'b0);
    wait_is(2, 1'b1);
    chk("done_queued", command_complete_flag, 1'b0);
    wait_is(0, 1'b1);
    chk("erase_idle", flash_mass_erase, 1'b0);
    chk("erase_count", erase_count, 8'h02);
    step();
    chk("done_irq", command_complete_irq, 1'b1);
    {buffer_empty_ie, command_complete_ie} = 2'h0;
    step();
    step();
    chk("done_irq_off", command_complete_irq, 1'b0);
    chk("empty_irq_off", buffer_empty_irq, 1'b0);
    // Two programs on one row: the pump must stay up across the hand-over
    do_cmd(`FCPC_CMD_PROGRAM);
    wait_is(4, 1'b1);
    chk("prog_addr", flash_addr, 16'h8000);
    chk("prog_data", flash_data, 16'h1234);
    do_cmd(`FCPC_CMD_PROGRAM);
    wait_is(2, 1'b1);
    chk("hv_kept", flash_hv_on, 1'b1);
    chk("prog_queued", command_complete_flag, 1'b0);
    wait_is(0, 1'b1);
    chk("hv_drop", flash_hv_on, 1'b0);
    // Second reset: array image holds low-range protection
    do_reset(8'hfb);
    chk("prot_load_low", protection_register, 8'hfb);
    pulse_prot(8'hff);
    chk("prot_remove", protection_register, 8'hfb);
    pulse_prot(8'hdb);
    chk("prot_add", protection_register, 8'hdb);
    pulse_prot(8'hfb);
    chk("prot_remove2", protection_register, 8'hdb);
    reserved_write_value = 8'ha5;
    reserved_write = 1'b1;
    step();
    reserved_write = 1'b0;
    chk("reserved", reserved_slot, 8'h00);
    do_cmd(`FCPC_CMD_MASS_ERASE);
    chk("violation", protection_violation_flag, 1'b1);
    chk("empty_kept", buffer_empty_flag, 1'b1);
    violation_clear = 1'b1;
    step();
    violation_clear = 1'b0;
    chk("hv_off", flash_hv_on, 1'b0);
    chk("violation_clr", protection_violation_flag, 1'b0);
    chk("no_erase", erase_count, 8'h00);
    close_out();
  end
endmodule
